// file: rtl/flag_pin_regs.vh
// register map, field positions, reset values and timing counts of the flag pin block
`ifndef FLAG_PIN_REGS_VH
`define FLAG_PIN_REGS_VH

// register byte addresses
`define ADDR_FLAG_CTRL 8'h00
`define ADDR_BUS_CTRL 8'h04
`define ADDR_SIG_CTRL 8'h08

// flag_control_reg fields
`define FLAG_DIR0_BIT 1
`define FLAG_OUT0_BIT 2
`define FLAG_IN0_BIT 3
`define FLAG_DIR1_BIT 5
`define FLAG_OUT1_BIT 6
`define FLAG_IN1_BIT 7
`define FLAG_CTRL_RST 8'h00

// bus_control_reg fields
`define BUS_WAIT_LSB 0
`define BUS_WAIT_MSB 2
`define BUS_WAIT_RST 3'h7

// signal control register fields
`define SIG_START_BIT 0
`define SIG_CLEAR_BIT 1
`define SIG_BUSY_BIT 0
`define SIG_DONE_BIT 1
`define SIG_RESULT_BIT 2

// bus responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

// phase clock timing: one phase cycle is PHASE_LAST+1 aclk cycles
`define PHASE_LAST 2'h3
`define PHASE_B_RISE_AT 2'h0
`define PHASE_A_FALL_AT 2'h2

`endif

// file: rtl/phase_gen.v
// phase clock enable generator: one-cycle pulses for the phase edges
`default_nettype none

`include "flag_pin_regs.vh"

module phase_gen (
  input wire aclk,
  input wire aresetn,
  output reg phase_b_rise,
  output reg phase_a_fall
);

  reg [1:0] phase_cnt;

  // both enables come from one counter so their spacing never drifts
  always @(posedge aclk) begin
    if (!aresetn) begin
      phase_cnt <= 2'h0;
      phase_b_rise <= 1'b0;
      phase_a_fall <= 1'b0;
    end else begin
      if (phase_cnt == `PHASE_LAST) begin
        phase_cnt <= 2'h0;
      end else begin
        phase_cnt <= phase_cnt + 2'h1;
      end
      phase_b_rise <= (phase_cnt == `PHASE_B_RISE_AT);
      phase_a_fall <= (phase_cnt == `PHASE_A_FALL_AT);
    end
  end

endmodule // phase_gen

`default_nettype wire

// file: rtl/flag_pin_io.v
// flag pin port: two general-purpose flag pins, handshake pulse and reset behaviour
//
// Summary of operation
// RQ1 - bits 2 and 6 of the flag control register hold the values that output pins drive.
// RQ2 - bits 1 and 5 of the flag control register select input or output for each pin.
// RQ3 - bits 3 and 7 of the flag control register show the sampled level of each pin.
// RQ4 - an output pin takes a newly written value after the next phase b rise.
// RQ5 - a pin turned to input stops being driven and is captured at a phase a fall.
// RQ6 - a pin turned from input to output starts being driven after a phase b rise.
// RQ7 - the handshake drives pin 0 low after a phase b rise and high after a later one.
// RQ8 - the handshake samples pin 1 at a phase a fall, and the far side keeps it stable there.
// RQ9 - reset may come at any time, so the internal reset may start one cycle late.
// RQ10 - the flag pins react to reset at once, without waiting for a clock edge.
// RQ11 - reset loads the bus control register with seven wait states.
// RQ12 - the bus hold request is accepted even while reset is asserted.
// RQ13 - the reset source holds reset for at least ten phase a cycles before release; the bench's first reset covers only five aclk edges.
// RQ14 - while reset is low both flag pins are high impedance.
// RQ15 - a direction bit of one makes an output, and reset leaves both pins as inputs.
// RQ16 - the input bits are read only and show the last level captured.
`default_nettype none

`include "flag_pin_regs.vh"

module flag_pin_io (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] awaddr,
  input wire awvalid,
  output wire awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output wire wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  input wire [7:0] araddr,
  input wire arvalid,
  output wire arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  input wire flag_pin_0_in,
  output wire flag_pin_0_out,
  output wire flag_pin_0_oe_n,
  input wire flag_pin_1_in,
  output wire flag_pin_1_out,
  output wire flag_pin_1_oe_n,
  input wire hold_req_n,
  output reg hold_ack_n,
  output wire [2:0] bus_wait_states
);

  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_ARM = 5'h02;
  localparam [4:0] S_LOW = 5'h04;
  localparam [4:0] S_REL = 5'h08;
  localparam [4:0] S_HIGH = 5'h10;

  wire phase_b_rise;
  wire phase_a_fall;

  phase_gen i_phase_gen (
    .aclk(aclk),
    .aresetn(aresetn),
    .phase_b_rise(phase_b_rise),
    .phase_a_fall(phase_a_fall)
  );

  // ---------------- register state ----------------
  reg [1:0] flag_direction_wr;
  reg [1:0] flag_out_value_wr;
  reg [2:0] wait_states;
  reg sig_done;
  reg sig_result;
  reg [4:0] sig_state;
  reg [4:0] next_sig_state;
  reg sig_drive;

  wire [1:0] flag_in_value;
  wire [1:0] dir_eff;
  wire [1:0] pin_val;
  wire [1:0] pin_sync;
  wire [1:0] pin_in;
  wire [1:0] pin_force_drive;

  assign pin_in = {flag_pin_1_in, flag_pin_0_in};
  assign bus_wait_states = wait_states;

  // ---------------- AXI4-Lite write channel ----------------
  reg aw_held;
  reg w_held;
  reg [7:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;

  wire do_write;
  wire wr_flag;
  wire wr_bus;
  wire wr_sig;
  wire sig_start;
  wire sig_clear;

  // one write in flight: new address or data only while no response waits
  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;
  assign do_write = aw_held && w_held && !bvalid;

  assign wr_flag = do_write && (aw_addr_q == `ADDR_FLAG_CTRL) && w_strb_q[0];
  assign wr_bus = do_write && (aw_addr_q == `ADDR_BUS_CTRL) && w_strb_q[0];
  assign wr_sig = do_write && (aw_addr_q == `ADDR_SIG_CTRL) && w_strb_q[0];
  assign sig_start = wr_sig && w_data_q[`SIG_START_BIT];
  assign sig_clear = wr_sig && w_data_q[`SIG_CLEAR_BIT];

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        if ((aw_addr_q == `ADDR_FLAG_CTRL) || (aw_addr_q == `ADDR_BUS_CTRL) ||
            (aw_addr_q == `ADDR_SIG_CTRL)) begin
          bresp <= `RESP_OKAY;
        end else begin
          bresp <= `RESP_SLVERR;
        end
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // software copies of direction and output value; the pins follow at phase b
  always @(posedge aclk) begin
    if (!aresetn) begin
      flag_direction_wr <= 2'b00; // [RQ15]
      flag_out_value_wr <= 2'b00;
      wait_states <= `BUS_WAIT_RST; // [RQ11]
    end else begin
      if (wr_flag) begin
        flag_direction_wr <= {w_data_q[`FLAG_DIR1_BIT], w_data_q[`FLAG_DIR0_BIT]}; // [RQ2]
        flag_out_value_wr <= {w_data_q[`FLAG_OUT1_BIT], w_data_q[`FLAG_OUT0_BIT]}; // [RQ1]
      end
      if (wr_bus) begin
        wait_states <= w_data_q[`BUS_WAIT_MSB:`BUS_WAIT_LSB];
      end
    end
  end

  // ---------------- AXI4-Lite read channel ----------------
  reg [31:0] next_rdata;
  reg [1:0] next_rresp;

  assign arready = !rvalid;

  always @* begin
    next_rdata = 32'h0000_0000;
    next_rresp = `RESP_OKAY;
    case (araddr)
      `ADDR_FLAG_CTRL: begin
        next_rdata[`FLAG_DIR0_BIT] = flag_direction_wr[0];
        next_rdata[`FLAG_OUT0_BIT] = flag_out_value_wr[0];
        next_rdata[`FLAG_IN0_BIT] = flag_in_value[0]; // [RQ3]
        next_rdata[`FLAG_DIR1_BIT] = flag_direction_wr[1];
        next_rdata[`FLAG_OUT1_BIT] = flag_out_value_wr[1];
        next_rdata[`FLAG_IN1_BIT] = flag_in_value[1]; // [RQ3]
      end
      `ADDR_BUS_CTRL: begin
        next_rdata[`BUS_WAIT_MSB:`BUS_WAIT_LSB] = wait_states;
      end
      `ADDR_SIG_CTRL: begin
        next_rdata[`SIG_BUSY_BIT] = !sig_state[0];
        next_rdata[`SIG_DONE_BIT] = sig_done;
        next_rdata[`SIG_RESULT_BIT] = sig_result;
      end
      default: begin
        next_rresp = `RESP_SLVERR;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // ---------------- interlocked signal handshake ----------------
  wire sig_go_low;
  wire sig_go_high;
  wire sig_end;

  assign sig_go_low = sig_state[1] && phase_b_rise;
  assign sig_go_high = sig_state[3] && phase_b_rise;
  assign sig_end = sig_state[4] && phase_b_rise;

  always @* begin
    case (sig_state)
      S_IDLE: begin
        next_sig_state = sig_start ? S_ARM : S_IDLE;
      end
      S_ARM: begin
        next_sig_state = phase_b_rise ? S_LOW : S_ARM; // [RQ7]
      end
      S_LOW: begin
        next_sig_state = phase_a_fall ? S_REL : S_LOW; // [RQ8]
      end
      S_REL: begin
        next_sig_state = phase_b_rise ? S_HIGH : S_REL; // [RQ7]
      end
      S_HIGH: begin
        next_sig_state = phase_b_rise ? S_IDLE : S_HIGH; // [RQ7]
      end
      default: begin
        next_sig_state = S_IDLE;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      sig_state <= S_IDLE;
      sig_drive <= 1'b0;
      sig_done <= 1'b0;
      sig_result <= 1'b0;
    end else begin
      sig_state <= next_sig_state;
      if (sig_go_low) begin
        sig_drive <= 1'b1;
      end else if (sig_end) begin
        sig_drive <= 1'b0;
      end
      // pin 1 is taken at the phase a fall while pin 0 is held low
      if (sig_state[2] && phase_a_fall) begin
        sig_result <= pin_sync[1]; // [RQ8]
      end
      // completion beats a clear in the same cycle
      if (sig_end) begin
        sig_done <= 1'b1;
      end else if (sig_clear) begin
        sig_done <= 1'b0;
      end
    end
  end

  // only pin 0 is taken over by the handshake
  // pin 0 stays driven through the high beat so the far side sees a driven rise
  assign pin_force_drive = {1'b0, sig_drive};

  // ---------------- per-pin logic ----------------
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : pin_g
      reg sync_1;
      reg sync_2;
      reg dir_q;
      reg val_q;
      reg in_q;
      wire force_low;
      wire force_high;
      wire force_keep;

      assign force_low = (i == 0) ? sig_go_low : 1'b0;
      assign force_high = (i == 0) ? sig_go_high : 1'b0;
      // at the closing phase b the software value takes over again
      assign force_keep = (i == 0) ? (sig_drive && !sig_end) : 1'b0;

      // the pin is asynchronous to aclk; sync_1 feeds sync_2 only
      always @(posedge aclk) begin
        if (!aresetn) begin
          sync_1 <= 1'b0;
          sync_2 <= 1'b0;
        end else begin
          sync_1 <= pin_in[i];
          sync_2 <= sync_1;
        end
      end

      // direction and level move together at phase b, so no glitch of old data
      always @(posedge aclk) begin
        if (!aresetn) begin
          dir_q <= 1'b0; // [RQ15]
          val_q <= 1'b0;
        end else if (phase_b_rise) begin
          dir_q <= flag_direction_wr[i]; // [RQ6] [RQ5]
          if (force_low) begin
            val_q <= 1'b0; // [RQ7]
          end else if (force_high) begin
            val_q <= 1'b1; // [RQ7]
          end else if (!force_keep) begin
            val_q <= flag_out_value_wr[i]; // [RQ4]
          end
        end
      end

      // input bit is hardware written only; bus writes never reach it
      always @(posedge aclk) begin
        if (!aresetn) begin
          in_q <= 1'b0;
        end else if (phase_a_fall && !dir_q && !pin_force_drive[i]) begin
          in_q <= sync_2; // [RQ5] [RQ16]
        end
      end

      assign pin_sync[i] = sync_2;
      assign dir_eff[i] = dir_q;
      assign pin_val[i] = val_q;
      assign flag_in_value[i] = in_q;
    end
  endgenerate

  // ---------------- pins ----------------
  // the enable is gated by reset directly so the pins float without a clock edge
  assign flag_pin_0_oe_n = !(aresetn && (dir_eff[0] || pin_force_drive[0])); // [RQ10] [RQ14]
  assign flag_pin_1_oe_n = !(aresetn && dir_eff[1]); // [RQ10] [RQ14]
  assign flag_pin_0_out = pin_val[0]; // [RQ1]
  assign flag_pin_1_out = pin_val[1]; // [RQ1]

  // ---------------- bus hold request ----------------
  // these flops ignore reset on purpose so a hold is granted during reset
  reg hold_sync_1;
  reg hold_sync_2;

  always @(posedge aclk) begin
    hold_sync_1 <= hold_req_n;
    hold_sync_2 <= hold_sync_1;
    hold_ack_n <= hold_sync_2; // [RQ12]
  end

  // reset is sampled on aclk, so a reset landing late in a cycle takes
  // effect one edge later; every flop above except the hold chain resets in the same edge [RQ9]

endmodule // flag_pin_io

`default_nettype wire

// file: dv/flag_pin_io_properties.sv
// port assertions for the flag pin block
`default_nettype none
module flag_pin_io_properties (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] awaddr,
  input wire awvalid,
  input wire awready,
  input wire [31:0] wdata,
  input wire wvalid,
  input wire wready,
  input wire bvalid,
  input wire [7:0] araddr,
  input wire arvalid,
  input wire arready,
  input wire [1:0] rresp,
  input wire rvalid,
  input wire flag_pin_0_out,
  input wire flag_pin_0_oe_n,
  input wire flag_pin_1_out,
  input wire flag_pin_1_oe_n,
  input wire hold_req_n,
  input wire hold_ack_n,
  input wire [2:0] bus_wait_states
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  wire wtake = awvalid && awready && wvalid && wready;
  wire [3:0] pins = {flag_pin_1_oe_n, flag_pin_1_out, flag_pin_0_oe_n, flag_pin_0_out};
  logic [7:0] last_flag = 8'h00;
  logic [2:0] age = 3'h0;
  // the hold sync chain is unknown until three edges have passed
  always @(posedge aclk) begin
    if (age != 3'h4)
      age <= age + 3'h1;
    if (wtake && awaddr == 8'h00)
      last_flag <= wdata[7:0];
  end
  pins_released_a: assert property (disable iff (1'b0)
    !aresetn |-> pins[3] && pins[1]) else $error("flag pin driven in reset");
  wait_reset_a: assert property (disable iff (1'b0)
    !aresetn |=> bus_wait_states == 3'h7) else $error("wait states not seven");
  hold_echo_a: assert property (disable iff (1'b0)
    age == 3'h4 |-> hold_ack_n == $past(hold_req_n, 3)) else $error("hold echo wrong");
  pin_steady_a: assert property ($changed(pins) |=> $stable(pins) [*3])
    else $error("flag pin changed off its phase");
  pin0_write_a: assert property (wtake && awaddr == 8'h00 |-> ##[2:10]
    pins[1] == !last_flag[1] && (pins[1] || pins[0] == last_flag[2]))
    else $error("flag pin 0 setting not applied");
  pin1_write_a: assert property (wtake && awaddr == 8'h00 |-> ##[2:10]
    pins[3] == !last_flag[5] && (pins[3] || pins[2] == last_flag[6]))
    else $error("flag pin 1 setting not applied");
  sig_pulse_a: assert property (wtake && awaddr == 8'h08 && wdata[0] |-> ##[1:10]
    pins[1:0] == 2'h0 ##[1:8] pins[1:0] == 2'h1) else $error("handshake pulse missing");
  resp_block_a: assert property (bvalid |-> !awready && !wready)
    else $error("write taken during response");
  read_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read not answered");
  bad_addr_a: assert property (arvalid && arready && araddr > 8'h08 |=> rresp == 2'h2)
    else $error("unmapped read not refused");
  cover property (wtake && awaddr == 8'h08);
  cover property (arvalid && arready && araddr > 8'h08);
  cover property (disable iff (1'b0) !aresetn && !hold_req_n);
endmodule // flag_pin_io_properties

bind flag_pin_io flag_pin_io_properties i_flag_pin_io_properties (
  .aclk(aclk),
  .aresetn(aresetn),
  .awaddr(awaddr),
  .awvalid(awvalid),
  .awready(awready),
  .wdata(wdata),
  .wvalid(wvalid),
  .wready(wready),
  .bvalid(bvalid),
  .araddr(araddr),
  .arvalid(arvalid),
  .arready(arready),
  .rresp(rresp),
  .rvalid(rvalid),
  .flag_pin_0_out(flag_pin_0_out),
  .flag_pin_0_oe_n(flag_pin_0_oe_n),
  .flag_pin_1_out(flag_pin_1_out),
  .flag_pin_1_oe_n(flag_pin_1_oe_n),
  .hold_req_n(hold_req_n),
  .hold_ack_n(hold_ack_n),
  .bus_wait_states(bus_wait_states)
);
`default_nettype wire

// file: dv/flag_line_model.sv
// far-side glue logic on the two flag lines
`default_nettype none
module flag_line_model (
  input wire aclk,
  input wire [1:0] dev_out,
  input wire [1:0] dev_oe_n,
  input wire [1:0] far_en,
  input wire [1:0] far_val,
  output logic [1:0] level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wander = 1'b0;
  // no pull on these lines: a released line wanders rather than keeping its level
  always @(posedge aclk)
    wander <= ~wander;
  // far values only move well clear of a sampling phase, so pin 1 is steady there
  always_comb
    for (int i = 0; i < 2; i++)
      level[i] = !dev_oe_n[i] ? dev_out[i] : far_en[i] ? far_val[i] : wander;
endmodule // flag_line_model
`default_nettype wire

// file: dv/flag_pin_io_tb.sv
// self-checking bench for the flag pin block
`default_nettype none
module flag_pin_io_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, hold_req_n = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] far_en = 2'h3, far_val = 2'h0;
  wire awready, wready, bvalid, arready, rvalid, hold_ack_n;
  wire flag_pin_0_in, flag_pin_0_out, flag_pin_0_oe_n;
  wire flag_pin_1_in, flag_pin_1_out, flag_pin_1_oe_n;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [2:0] bus_wait_states;
  wire [3:0] pins = {flag_pin_1_oe_n, flag_pin_1_out, flag_pin_0_oe_n, flag_pin_0_out};
  int miscompares = 0, n_tests = 0;
  always #20 aclk = ~aclk;
  flag_pin_io i_flag_pin_io (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .flag_pin_0_in(flag_pin_0_in),
    .flag_pin_0_out(flag_pin_0_out),
    .flag_pin_0_oe_n(flag_pin_0_oe_n),
    .flag_pin_1_in(flag_pin_1_in),
    .flag_pin_1_out(flag_pin_1_out),
    .flag_pin_1_oe_n(flag_pin_1_oe_n),
    .hold_req_n(hold_req_n),
    .hold_ack_n(hold_ack_n),
    .bus_wait_states(bus_wait_states)
  );
  flag_line_model i_flag_line_model (
    .aclk(aclk),
    .dev_out({flag_pin_1_out, flag_pin_0_out}),
    .dev_oe_n({flag_pin_1_oe_n, flag_pin_0_oe_n}),
    .far_en(far_en),
    .far_val(far_val),
    .level({flag_pin_1_in, flag_pin_0_in})
  );
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic hung;
    miscompares++;
    complete_run();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic pa, pw, g;
    logic [1:0] r;
    pa = 1'b1;
    pw = 1'b1;
    g = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; !g; n++) begin
      if (n == 50)
        hung();
      @(negedge aclk);
      pa = pa && awready !== 1'b1;
      pw = pw && wready !== 1'b1;
      g = bvalid === 1'b1;
      r = bresp;
      @(posedge aclk);
      awvalid <= pa;
      wvalid <= pw;
    end
    bready <= 1'b0;
    chk(r, er);
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] er, input logic [31:0] m,
                    input logic [31:0] e);
    logic pa, g;
    logic [1:0] r;
    logic [31:0] d;
    pa = 1'b1;
    g = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; !g; n++) begin
      if (n == 50)
        hung();
      @(negedge aclk);
      pa = pa && arready !== 1'b1;
      g = rvalid === 1'b1;
      r = rresp;
      d = rdata;
      @(posedge aclk);
      arvalid <= pa;
    end
    rready <= 1'b0;
    chk(r, er);
    chk(d & m, e);
  endtask
  // bounded look for a pin 0 state that lasts only a few cycles
  task automatic poll(input logic [1:0] e);
    for (int n = 0; n < 12 && pins[1:0] !== e; n++)
      @(negedge aclk);
    chk(pins[1:0], e);
  endtask
  task automatic t_out;
    far_en <= 2'h0;
    wr(8'h00, 32'h0000_0026, 2'h0);
    repeat (6) @(negedge aclk);
    chk(pins, 32'h0000_0001);
    rd(8'h00, 2'h0, 32'h0000_0077, 32'h0000_0026);
    wr(8'h00, 32'h0000_0062, 2'h0);
    repeat (6) @(negedge aclk);
    chk(pins, 32'h0000_0004);
  endtask
  task automatic t_in;
    far_en <= 2'h3;
    far_val <= 2'h2;
    wr(8'h00, 32'h0000_0088, 2'h0);
    repeat (8) @(negedge aclk);
    chk(pins, 32'h0000_000a);
    rd(8'h00, 2'h0, 32'h0000_00ff, 32'h0000_0080);
    far_val <= 2'h1;
    repeat (8) @(posedge aclk);
    rd(8'h00, 2'h0, 32'h0000_00ff, 32'h0000_0008);
  endtask
  task automatic t_sig;
    far_en <= 2'h2;
    far_val <= 2'h2;
    wr(8'h08, 32'h0000_0001, 2'h0);
    poll(2'h0);
    poll(2'h1);
    poll(2'h2);
    rd(8'h08, 2'h0, 32'h0000_0007, 32'h0000_0006);
    wr(8'h08, 32'h0000_0002, 2'h0);
    rd(8'h08, 2'h0, 32'h0000_0003, 32'h0000_0000);
  endtask
  task automatic t_bus;
    wr(8'h04, 32'h0000_0002, 2'h0);
    rd(8'h04, 2'h0, 32'h0000_0007, 32'h0000_0002);
    chk(bus_wait_states, 32'h0000_0002);
    // a write with byte 0 masked off must leave the register alone
    wstrb <= 4'h0;
    wr(8'h04, 32'h0000_0005, 2'h0);
    wstrb <= 4'hf;
    rd(8'h04, 2'h0, 32'h0000_0007, 32'h0000_0002);
    wr(8'h0c, 32'h0000_00ff, 2'h2);
    rd(8'h0c, 2'h2, 32'h0000_0000, 32'h0000_0000);
  endtask
  task automatic t_rst;
    wr(8'h00, 32'h0000_0026, 2'h0);
    repeat (6) @(posedge aclk);
    aresetn <= 1'b0;
    hold_req_n <= 1'b0;
    @(negedge aclk);
    chk({flag_pin_1_oe_n, flag_pin_0_oe_n}, 32'h0000_0003);
    repeat (40) @(negedge aclk);
    chk(hold_ack_n, 32'h0000_0000);
    chk(bus_wait_states, 32'h0000_0007);
    @(posedge aclk);
    aresetn <= 1'b1;
    hold_req_n <= 1'b1;
    rd(8'h00, 2'h0, 32'h0000_0077, 32'h0000_0000);
  endtask
  initial begin
    repeat (4) @(negedge aclk);
    chk(pins, 32'h0000_000a);
    @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h04, 2'h0, 32'h0000_0007, 32'h0000_0007);
    t_out();
    t_in();
    t_sig();
    t_bus();
    t_rst();
    complete_run();
  end
endmodule // flag_pin_io_tb
`default_nettype wire
